// *** mis_pkg.sv ***
// Package: register map, field positions, reset values and bus carriers
package mis_pkg;

  localparam int unsigned ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_EXT_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EXT_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h08;

  // ext_control_interrupt_one fields
  localparam int unsigned ONE_COLL_FLAG = 5;
  localparam int unsigned ONE_COLL_MASK = 4;
  localparam int unsigned ONE_TXS_FLAG  = 3;
  localparam int unsigned ONE_TXS_MASK  = 2;

  // ext_control_interrupt_two fields
  localparam int unsigned TWO_TOK_DIS  = 15;
  localparam int unsigned TWO_LT_EN    = 14;
  localparam int unsigned TWO_SYS_FLAG = 11;
  localparam int unsigned TWO_SYS_EN   = 10;
  localparam int unsigned TWO_EXD_FLAG = 7;
  localparam int unsigned TWO_EXD_EN   = 6;

  // Control and status fields
  localparam int unsigned CTL_GIE    = 0;
  localparam int unsigned CTL_STOP   = 1;
  localparam int unsigned CTL_SWRST  = 2;
  localparam int unsigned CTL_PARITY_ERROR_RESPONSE = 3;
  localparam int unsigned CTL_SUMM   = 7;
  localparam int unsigned CTL_TRANSMIT_INTERRUPT_FLAG   = 8;

  // Bit of the second transmit descriptor word read as last-transmit flag
  localparam int unsigned DESC_LT_BIT = 28;

  // Reset values
  localparam logic RST_COLL_MASK = 1'b1;
  localparam logic RST_TXS_MASK  = 1'b1;
  localparam logic RST_TOK_DIS   = 1'b0;
  localparam logic RST_LT_EN     = 1'b0;
  localparam logic RST_SYS_EN    = 1'b0;
  localparam logic RST_EXD_EN    = 1'b0;
  localparam logic RST_GIE       = 1'b0;
  localparam logic RST_STOP      = 1'b0;
  localparam logic RST_PARITY_ERROR_RESPONSE    = 1'b0;

  // Flag indices
  localparam int unsigned FLAG_N    = 5;
  localparam int unsigned F_COLL    = 0;
  localparam int unsigned F_TXS     = 1;
  localparam int unsigned F_SYS     = 2;
  localparam int unsigned F_EXD     = 3;
  localparam int unsigned F_TRANSMIT_INTERRUPT_FLAG    = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } mis_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mis_axil_rsp_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } mis_wr_state_t;

endpackage

// *** mis_flag.sv ***
// Sticky status flag: reset sources dominate, a set beats a host clear
`timescale 1ns/1ns
module mis_flag (
  input  wire logic mclk,
  input  wire logic rstClr,
  input  wire logic setEvt,
  input  wire logic clrEvt,
  output logic      flag
);

  always_ff @(posedge mclk) begin
    if (rstClr) begin
      flag <= 1'b0;
    end else if (setEvt) begin
      flag <= 1'b1;
    end else if (clrEvt) begin
      flag <= 1'b0;
    end
  end

endmodule

// *** mis_top.sv ***
// Interrupt status and mask slice with its AXI4-Lite register slave
// Overview of operation
// - Collision-overflow mask set keeps collision-overflow flag out of summary interrupt.
// - Collision-overflow mask goes to one on hard or soft reset; stop ignored.
// - Transmit-start flag sets whenever a frame transmission begins.
// - Transmit-start flag drives pin only with global enable one and mask zero.
// - Transmit-start flag always accessible; write one clears, write zero keeps.
// - With last-transmit enable, last-transmit descriptor always sets transmit interrupt flag.
// - Transmit-OK disable accessible; cleared by hard or soft reset, stop ignored.
// - With last-transmit enable, descriptor word one bit 28 is last-transmit flag.
// - Last-transmit enable accessible; cleared by hard or soft reset, stop ignored.
// - System-error flag sets on parity error, master abort or target abort.
// - Parity error sets system-error flag regardless of parity-error-response bit.
// - System-error flag with its enable drives pin regardless of global enable.
// - Excess-deferral flag with enable drives pin and may set summary interrupt.
// - Excess-deferral flag write-one-clear; only hard reset clears it.
// - Excess-deferral enable cleared only by hard reset.
// - Bits 13-12 of second register are written zero; reads undefined.
// - Transmit-OK disable without last-transmit enable: only errors set transmit flag.
// - Transmit-OK disable has no effect while last-transmit enable is set.
// - Excess-deferral flag sets when transmitter suffers excessive deferral.
// - Transmit-start mask goes to one on hard or soft reset; stop ignored.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module mis_top (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire mis_pkg::mis_axil_req_t axiReq,
  output mis_pkg::mis_axil_rsp_t     axiRsp,
  input  wire logic                  collOvfEvt,
  input  wire logic                  txStartEvt,
  input  wire logic                  parityErrEvt,
  input  wire logic                  masterAbortEvt,
  input  wire logic                  targetAbortEvt,
  input  wire logic                  excessDeferEvt,
  input  wire logic                  txDoneEvt,
  input  wire logic                  txOk,
  input  wire logic [31:0]           txDescWordOne,
  output logic                       summaryInterrupt,
  output logic                       intaN
);

  function automatic logic [2:0] regSel(input logic [mis_pkg::ADDR_W-1:0] a);
    regSel = {a == mis_pkg::OFF_CTRL, a == mis_pkg::OFF_EXT_TWO, a == mis_pkg::OFF_EXT_ONE};
  endfunction

  mis_pkg::mis_wr_state_t wrState;
  logic                        awHeld;
  logic                        wHeld;
  logic [mis_pkg::ADDR_W-1:0]  awAddr;
  logic [31:0]                 wData;
  logic [3:0]                  wStrb;
  logic [1:0]                  bResp;
  logic                        rValid;
  logic [31:0]                 rData;
  logic [1:0]                  rResp;

  logic collMask;
  logic txsMask;
  logic tokDis;
  logic ltEn;
  logic sysEn;
  logic exdEn;
  logic gie;
  logic stopBit;
  logic parity_error_response;
  logic [mis_pkg::FLAG_N-1:0] flags;
  logic [mis_pkg::FLAG_N-1:0] flagSet;
  logic [mis_pkg::FLAG_N-1:0] flagW1c;
  logic [mis_pkg::FLAG_N-1:0] flagRst;

  // Write path: address and data taken in either order, committed together
  wire doWrite = (wrState == mis_pkg::WR_IDLE) && awHeld && wHeld;
  wire [2:0] wSel = regSel(awAddr);
  wire [2:0] rSel = regSel(axiReq.araddr);
  wire wrOne = doWrite && wSel[0];
  wire wrTwo = doWrite && wSel[1];
  wire wrCtl = doWrite && wSel[2];
  wire be0 = wStrb[0];
  wire be1 = wStrb[1];
  wire swReset = wrCtl && be0 && wData[mis_pkg::CTL_SWRST];
  wire stopSet = wrCtl && be0 && wData[mis_pkg::CTL_STOP];
  wire softOrHard = sys_rst || swReset;

  assign axiRsp.awready = (wrState == mis_pkg::WR_IDLE) && !awHeld;
  assign axiRsp.wready  = (wrState == mis_pkg::WR_IDLE) && !wHeld;
  assign axiRsp.bvalid  = (wrState == mis_pkg::WR_RESP);
  assign axiRsp.bresp   = bResp;
  assign axiRsp.arready = !rValid;
  assign axiRsp.rvalid  = rValid;
  assign axiRsp.rdata   = rData;
  assign axiRsp.rresp   = rResp;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrState <= mis_pkg::WR_IDLE;
    end else begin
      unique case (wrState)
        mis_pkg::WR_IDLE: begin
          if (doWrite) begin
            wrState <= mis_pkg::WR_RESP;
          end
        end
        mis_pkg::WR_RESP: begin
          if (axiReq.bready) begin
            wrState <= mis_pkg::WR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= '0;
      wData  <= '0;
      wStrb  <= '0;
      bResp  <= mis_pkg::RESP_OKAY;
    end else begin
      if (axiReq.awvalid && axiRsp.awready) begin
        awHeld <= 1'b1;
        awAddr <= axiReq.awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (axiReq.wvalid && axiRsp.wready) begin
        wHeld <= 1'b1;
        wData <= axiReq.wdata;
        wStrb <= axiReq.wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      if (doWrite) begin
        bResp <= (wSel == 3'h0) ? mis_pkg::RESP_SLVERR : mis_pkg::RESP_OKAY;
      end
    end
  end

  // Host-written control bits
  always_ff @(posedge mclk) begin
    if (softOrHard) begin
      collMask <= mis_pkg::RST_COLL_MASK;
      txsMask  <= mis_pkg::RST_TXS_MASK;
      tokDis   <= mis_pkg::RST_TOK_DIS;
      ltEn     <= mis_pkg::RST_LT_EN;
      sysEn    <= mis_pkg::RST_SYS_EN;
    end else begin
      if (wrOne && be0) begin
        collMask <= wData[mis_pkg::ONE_COLL_MASK];
        txsMask  <= wData[mis_pkg::ONE_TXS_MASK];
      end
      if (wrTwo && be1) begin
        tokDis <= wData[mis_pkg::TWO_TOK_DIS];
        ltEn   <= wData[mis_pkg::TWO_LT_EN];
        sysEn  <= wData[mis_pkg::TWO_SYS_EN];
      end
    end
  end

  // Survives soft reset and stop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exdEn <= mis_pkg::RST_EXD_EN;
    end else if (wrTwo && be0) begin
      exdEn <= wData[mis_pkg::TWO_EXD_EN];
    end
  end

  // Stop reset drops the global enable, hence system errors bypass it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gie     <= mis_pkg::RST_GIE;
      stopBit <= mis_pkg::RST_STOP;
      parity_error_response  <= mis_pkg::RST_PARITY_ERROR_RESPONSE;
    end else if (wrCtl && be0) begin
      gie     <= wData[mis_pkg::CTL_GIE] && !swReset && !stopSet;
      stopBit <= wData[mis_pkg::CTL_STOP];
      parity_error_response  <= wData[mis_pkg::CTL_PARITY_ERROR_RESPONSE];
    end
  end

  // Transmit interrupt qualification
  wire descLast = txDescWordOne[mis_pkg::DESC_LT_BIT];
  wire tintLt   = ltEn && (descLast || !txOk);
  wire tintStd  = !ltEn && (!txOk || !tokDis);
  wire tintSet  = txDoneEvt && (tintLt || tintStd);
  // Parity-error-response is kept for software only
  wire sysErr   = parityErrEvt || masterAbortEvt || targetAbortEvt;

  assign flagSet[mis_pkg::F_COLL] = collOvfEvt;
  assign flagSet[mis_pkg::F_TXS]  = txStartEvt;
  assign flagSet[mis_pkg::F_SYS]  = sysErr;
  assign flagSet[mis_pkg::F_EXD]  = excessDeferEvt;
  assign flagSet[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG] = tintSet;

  assign flagW1c[mis_pkg::F_COLL] = wrOne && be0 && wData[mis_pkg::ONE_COLL_FLAG];
  assign flagW1c[mis_pkg::F_TXS]  = wrOne && be0 && wData[mis_pkg::ONE_TXS_FLAG];
  assign flagW1c[mis_pkg::F_SYS]  = wrTwo && be1 && wData[mis_pkg::TWO_SYS_FLAG];
  assign flagW1c[mis_pkg::F_EXD]  = wrTwo && be0 && wData[mis_pkg::TWO_EXD_FLAG];
  assign flagW1c[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG] = wrCtl && be1 && wData[mis_pkg::CTL_TRANSMIT_INTERRUPT_FLAG];

  assign flagRst[mis_pkg::F_COLL] = softOrHard || stopSet;
  assign flagRst[mis_pkg::F_TXS]  = softOrHard || stopSet;
  assign flagRst[mis_pkg::F_SYS]  = softOrHard;
  assign flagRst[mis_pkg::F_EXD]  = sys_rst;
  assign flagRst[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG] = softOrHard || stopSet;

  genvar gi;
  generate
    for (gi = 0; gi < mis_pkg::FLAG_N; gi++) begin : gFlag
      mis_flag uFlag (
        .mclk   (mclk),
        .rstClr (flagRst[gi]),
        .setEvt (flagSet[gi]),
        .clrEvt (flagW1c[gi]),
        .flag   (flags[gi])
      );
    end
  endgenerate

  // Interrupt combining
  wire collPart = flags[mis_pkg::F_COLL] && !collMask;
  wire txsPart  = flags[mis_pkg::F_TXS] && !txsMask;
  wire sysPart  = flags[mis_pkg::F_SYS] && sysEn;
  wire exdPart  = flags[mis_pkg::F_EXD] && exdEn;
  wire tintPart = flags[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG];
  wire next_summary = collPart || txsPart || sysPart || exdPart || tintPart;
  wire next_pin = (gie && (collPart || txsPart || tintPart)) || sysPart || exdPart;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      summaryInterrupt <= 1'b0;
      intaN            <= 1'b1;
    end else begin
      summaryInterrupt <= next_summary;
      intaN            <= !next_pin;
    end
  end

  // Read path; reserved bits, bits 13-12 included, return zero
  wire [31:0] rdOne = {26'h0, flags[mis_pkg::F_COLL], collMask,
                       flags[mis_pkg::F_TXS], txsMask, 2'h0};
  wire [31:0] rdTwo = {16'h0, tokDis, ltEn, 2'h0, flags[mis_pkg::F_SYS], sysEn,
                       2'h0, flags[mis_pkg::F_EXD], exdEn, 6'h0};
  wire [31:0] rdCtl = {23'h0, flags[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG], summaryInterrupt, 3'h0,
                       parity_error_response, 1'b0, stopBit, gie};
  wire [31:0] rdMux = ({32{rSel[0]}} & rdOne) | ({32{rSel[1]}} & rdTwo) |
                      ({32{rSel[2]}} & rdCtl);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rValid <= 1'b0;
      rData  <= '0;
      rResp  <= mis_pkg::RESP_OKAY;
    end else if (axiReq.arvalid && !rValid) begin
      rValid <= 1'b1;
      rData  <= rdMux;
      rResp  <= (rSel == 3'h0) ? mis_pkg::RESP_SLVERR : mis_pkg::RESP_OKAY;
    end else if (axiReq.rready) begin
      rValid <= 1'b0;
    end
  end

  // Checks
  sequence swRstSeq;
    swReset;
  endsequence

  sequence txOkDoneSeq;
    txDoneEvt && txOk && tokDis && !ltEn && !flags[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG];
  endsequence

  collMasked_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (flags == 5'h01 && collMask) |=> !summaryInterrupt)
    else $error("masked collision flag reached summary");

  collMaskRst_a: assert property (@(posedge mclk) disable iff (sys_rst)
    swRstSeq |=> collMask && txsMask)
    else $error("mask not set by soft reset");

  txStartSet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (txStartEvt && !stopSet && !swReset) |=> flags[mis_pkg::F_TXS])
    else $error("transmit start flag not set");

  txStartPin_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (flags[mis_pkg::F_TXS] && !txsMask && gie) |=> !intaN)
    else $error("transmit start did not raise pin");

  txStartClr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (flagW1c[mis_pkg::F_TXS] && !txStartEvt) |=> !flags[mis_pkg::F_TXS])
    else $error("write one did not clear transmit start");

  lastTxSet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (txDoneEvt && ltEn && txDescWordOne[mis_pkg::DESC_LT_BIT] && !softOrHard && !stopSet)
      |=> flags[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG])
    else $error("last transmit did not set transmit flag");

  tokOkQuiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    txOkDoneSeq |=> !flags[mis_pkg::F_TRANSMIT_INTERRUPT_FLAG])
    else $error("successful transmit set flag while disabled");

  sysErrPin_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (flags[mis_pkg::F_SYS] && sysEn) |=> !intaN ##1
      (!intaN || !$past(flags[mis_pkg::F_SYS]) || !$past(sysEn)))
    else $error("system error did not raise pin");

  exdHold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (swRstSeq and (flags[mis_pkg::F_EXD] && !flagW1c[mis_pkg::F_EXD])) |=> flags[mis_pkg::F_EXD])
    else $error("soft reset cleared excess deferral flag");

  exdEnHold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    swReset |=> $stable(exdEn))
    else $error("soft reset changed excess deferral enable");

endmodule

// *** mis_top_tb.sv ***
// Self-checking bench for the interrupt status and mask slice
`timescale 1ns/1ns
module mis_top_tb;
  logic                   mclk;
  logic                   sys_rst;
  mis_pkg::mis_axil_req_t req;
  mis_pkg::mis_axil_rsp_t rsp;
  logic [6:0]             evt;
  logic                   txOk;
  logic [31:0]            txDesc;
  logic                   summaryInterrupt;
  logic                   intaN;
  logic [31:0]            rd;
  logic [1:0]             resp;
  logic [4:0]             tab [7];
  int                     failures;
  int                     comparisons;
  int                     i;

  localparam logic [7:0] ONE = mis_pkg::OFF_EXT_ONE;
  localparam logic [7:0] TWO = mis_pkg::OFF_EXT_TWO;
  localparam logic [7:0] CTL = mis_pkg::OFF_CTRL;

  mis_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .axiReq(req), .axiRsp(rsp),
    .collOvfEvt(evt[0]), .txStartEvt(evt[1]), .parityErrEvt(evt[2]),
    .masterAbortEvt(evt[3]), .targetAbortEvt(evt[4]), .excessDeferEvt(evt[5]),
    .txDoneEvt(evt[6]), .txOk(txOk), .txDescWordOne(txDesc),
    .summaryInterrupt(summaryInterrupt), .intaN(intaN));

  always #5 mclk = ~mclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A bus that never answers would hang the run
  task automatic hang();
    failures++;
    $display("CHECK FAILED bus answer expected within bound seen none");
    finish_test();
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic awT, wT, bT;
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    bT = 1'b0;
    for (n = 0; n < 40 && !bT; n++) begin
      @(negedge mclk);
      awT = req.awvalid && rsp.awready;
      wT = req.wvalid && rsp.wready;
      bT = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge mclk);
      if (awT) req.awvalid <= 1'b0;
      if (wT) req.wvalid <= 1'b0;
      if (bT) req.bready <= 1'b0;
    end
    if (!bT) hang();
  endtask

  task automatic axiRead(input logic [7:0] a);
    int n;
    logic arT, rT;
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    rT = 1'b0;
    for (n = 0; n < 40 && !rT; n++) begin
      @(negedge mclk);
      arT = req.arvalid && rsp.arready;
      rT = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge mclk);
      if (arT) req.arvalid <= 1'b0;
      if (rT) req.rready <= 1'b0;
    end
    if (!rT) hang();
  endtask

  // Reserved bits are masked off: their read value is not defined
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    axiRead(a);
    check($sformatf("register %h", a), rd & m, exp);
  endtask

  task automatic pinChk(input logic s, input logic n);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("summaryInterrupt", {31'h0, summaryInterrupt}, {31'h0, s});
    check("intaN", {31'h0, intaN}, {31'h0, n});
  endtask

  task automatic pulse(input logic [6:0] e, input logic ok, input logic lt);
    @(posedge mclk);
    evt <= e;
    txOk <= ok;
    txDesc <= {3'h0, lt, 28'h0};
    @(posedge mclk);
    evt <= 7'h00;
  endtask

  task automatic hardReset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    req = '0;
    evt = 7'h00;
    txOk = 1'b0;
    txDesc = 32'h0;
    failures = 0;
    comparisons = 0;
    // Disable, last enable, success, descriptor bit, expected flag
    tab = '{5'b00101, 5'b10100, 5'b10001, 5'b11111, 5'b01100, 5'b11100, 5'b01001};
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rdChk(ONE, 32'h3c, 32'h14);
    rdChk(TWO, 32'hccc0, 32'h0);
    pinChk(1'b0, 1'b1);
    axiWrite(8'h0c, 32'hffff_ffff);
    check("write response", {30'h0, resp}, {30'h0, mis_pkg::RESP_SLVERR});
    axiRead(8'h0c);
    check("read response", {30'h0, resp}, {30'h0, mis_pkg::RESP_SLVERR});
    $display("test reset and map done");
    pulse(7'h01, 1'b0, 1'b0);
    rdChk(ONE, 32'h3c, 32'h34);
    pinChk(1'b0, 1'b1);
    axiWrite(ONE, 32'h04);
    check("write response ok", {30'h0, resp}, {30'h0, mis_pkg::RESP_OKAY});
    rdChk(ONE, 32'h3c, 32'h24);
    check("read response ok", {30'h0, resp}, {30'h0, mis_pkg::RESP_OKAY});
    pinChk(1'b1, 1'b1);
    axiWrite(CTL, 32'h1);
    pinChk(1'b1, 1'b0);
    axiWrite(ONE, 32'h24);
    rdChk(ONE, 32'h3c, 32'h04);
    pinChk(1'b0, 1'b1);
    $display("test collision overflow done");
    pulse(7'h02, 1'b0, 1'b0);
    rdChk(ONE, 32'h3c, 32'h0c);
    pinChk(1'b0, 1'b1);
    axiWrite(ONE, 32'h00);
    rdChk(ONE, 32'h3c, 32'h08);
    pinChk(1'b1, 1'b0);
    axiWrite(CTL, 32'h0);
    pinChk(1'b1, 1'b1);
    axiWrite(ONE, 32'h08);
    rdChk(ONE, 32'h3c, 32'h00);
    $display("test transmit start done");
    // Parity error, master abort and target abort taken with the response bit left at zero
    axiWrite(TWO, 32'h400);
    for (i = 0; i < 3; i++) begin
      pulse(7'h04 << i, 1'b0, 1'b0);
      rdChk(TWO, 32'hccc0, 32'hc00);
      pinChk(1'b1, 1'b0);
      axiWrite(TWO, 32'hc00);
      rdChk(TWO, 32'hccc0, 32'h400);
    end
    // Same parity error with the response bit set
    axiWrite(CTL, 32'h8);
    rdChk(CTL, 32'h8, 32'h8);
    pulse(7'h04, 1'b0, 1'b0);
    rdChk(TWO, 32'hccc0, 32'hc00);
    axiWrite(TWO, 32'hc00);
    axiWrite(CTL, 32'h0);
    $display("test system error done");
    axiWrite(TWO, 32'hc000);
    pulse(7'h20, 1'b0, 1'b0);
    rdChk(TWO, 32'hccc0, 32'hc080);
    pinChk(1'b0, 1'b1);
    axiWrite(TWO, 32'hc040);
    pinChk(1'b1, 1'b0);
    axiWrite(ONE, 32'h0);
    axiWrite(CTL, 32'h4);
    rdChk(ONE, 32'h3c, 32'h14);
    rdChk(TWO, 32'hccc0, 32'h00c0);
    axiWrite(TWO, 32'hc440);
    axiWrite(ONE, 32'h0);
    axiWrite(CTL, 32'h3);
    rdChk(CTL, 32'h10b, 32'h2);
    rdChk(ONE, 32'h3c, 32'h0);
    rdChk(TWO, 32'hccc0, 32'hc4c0);
    axiWrite(CTL, 32'h0);
    axiWrite(TWO, 32'hc480);
    rdChk(TWO, 32'hccc0, 32'hc400);
    pinChk(1'b0, 1'b1);
    axiWrite(TWO, 32'h40);
    pulse(7'h20, 1'b0, 1'b0);
    hardReset();
    rdChk(TWO, 32'hccc0, 32'h0);
    $display("test excess deferral and resets done");
    for (i = 0; i < 7; i++) begin
      axiWrite(TWO, {16'h0, tab[i][4:3], 14'h0});
      pulse(7'h40, tab[i][2], tab[i][1]);
      rdChk(CTL, 32'h100, {23'h0, tab[i][0], 8'h0});
      axiWrite(CTL, 32'h100);
    end
    $display("test transmit interrupt done");
    finish_test();
  end
endmodule
